// *** logic/uim_gate.v ***
// Per-source AND gate with registered output
`timescale 1ns/1ps
`include "uim_map.vh"

module uim_gate (
  clock,
  reset_n,
  raw_in,
  enable,
  gated_r
);
  input wire clock;
  input wire reset_n;
  input wire [`UIM_SRC_N-1:0] raw_in;
  input wire [`UIM_SRC_N-1:0] enable;
  output reg [`UIM_SRC_N-1:0] gated_r;

  genvar gi;
  generate
    for (gi = 0; gi < `UIM_SRC_N; gi = gi + 1) begin : g_src
      always @(posedge clock) begin
        if (!reset_n) begin
          gated_r[gi] <= 1'b0;
        end else begin
          gated_r[gi] <= raw_in[gi] & enable[gi];
        end
      end
    end
  endgenerate
endmodule

// *** logic/uim_map.vh ***
// Register map, field positions and reset values for the UART interrupt mask gate
//
// Function
// - Reading the mask register returns the seven held enable bits.
// - A source with enable bit 1 passes its raw condition to the output.
// - A source with enable bit 0 is blocked from the output.
// - Transmit enable sits at bit 5, read/write, resets to 0.
// - Receive enable sits at bit 4, read/write, resets to 0.
// - Bits 31:11 and 3:0 reserved; device reads zero, software preserves them.
`ifndef UIM_MAP_VH
`define UIM_MAP_VH

// ****************************************
// Register offsets
// ****************************************
`define UIM_OFS_MASK 12'h038
`define UIM_OFS_ISTAT 12'h040
`define UIM_OFS_IMASK 12'h044
`define UIM_ADDR_W 12

// ****************************************
// Mask field layout
// ****************************************
`define UIM_SRC_N 7
`define UIM_FIELD_LSB 4
`define UIM_FIELD_MSB 10
`define UIM_BIT_RX 4
`define UIM_BIT_TX 5
`define UIM_BIT_RT 6
`define UIM_BIT_FE 7
`define UIM_BIT_PE 8
`define UIM_BIT_BE 9
`define UIM_BIT_OE 10
`define UIM_MASK_RST 7'h00

// ****************************************
// Own interrupt status layout
// ****************************************
`define UIM_EV_N 2
`define UIM_EV_RISE 0
`define UIM_EV_WRITE 1
`define UIM_EV_RST 2'h0

// ****************************************
// Bus encodings
// ****************************************
`define UIM_HTRANS_NONSEQ 1'b1

`endif

// *** logic/uim_top.v ***
// UART interrupt mask register with AHB-Lite slave and masked source outputs
`timescale 1ns/1ps
`include "uim_map.vh"

module uim_top (
  clock,
  reset_n,
  hsel,
  haddr,
  htrans,
  hwrite,
  hsize,
  hwdata,
  hready,
  hrdata,
  hreadyout,
  hresp,
  raw_irq,
  masked_irq,
  irq
);
  input wire clock;
  input wire reset_n;
  input wire hsel;
  input wire [31:0] haddr;
  input wire [1:0] htrans;
  input wire hwrite;
  input wire [2:0] hsize;
  input wire [31:0] hwdata;
  input wire hready;
  output reg [31:0] hrdata;
  output reg hreadyout;
  output reg hresp;
  input wire [`UIM_SRC_N-1:0] raw_irq;
  output wire [`UIM_SRC_N-1:0] masked_irq;
  output reg irq;

  // ****************************************
  // Synchronise raw sources
  // ****************************************
  // Raw flags may come from another UART clock region; two stages first.
  reg [`UIM_SRC_N-1:0] raw_s1_r;
  reg [`UIM_SRC_N-1:0] raw_s2_r;
  reg [`UIM_SRC_N-1:0] raw_d_r;
  always @(posedge clock) begin
    if (!reset_n) begin
      raw_s1_r <= {`UIM_SRC_N{1'b0}};
      raw_s2_r <= {`UIM_SRC_N{1'b0}};
      raw_d_r <= {`UIM_SRC_N{1'b0}};
    end else begin
      raw_s1_r <= raw_irq;
      raw_s2_r <= raw_s1_r;
      raw_d_r <= raw_s2_r;
    end
  end

  // ****************************************
  // Bus address phase capture
  // ****************************************
  reg wr_pend_r;
  reg [`UIM_ADDR_W-1:0] wr_addr_r;
  reg [`UIM_SRC_N-1:0] mask_r;
  reg [`UIM_EV_N-1:0] istat_r;
  reg [`UIM_EV_N-1:0] imask_r;
  wire bus_go;
  wire [`UIM_ADDR_W-1:0] a_ofs;
  assign bus_go = hsel & htrans[1] & hready;
  assign a_ofs = haddr[`UIM_ADDR_W-1:0];

  function [31:0] rd_mux;
    input [`UIM_ADDR_W-1:0] ofs;
    input [`UIM_SRC_N-1:0] m;
    input [`UIM_EV_N-1:0] st;
    input [`UIM_EV_N-1:0] im;
    begin
      rd_mux = 32'h0000_0000;
      case (ofs)
        `UIM_OFS_MASK: rd_mux[`UIM_FIELD_MSB:`UIM_FIELD_LSB] = m;
        `UIM_OFS_ISTAT: rd_mux[`UIM_EV_N-1:0] = st;
        `UIM_OFS_IMASK: rd_mux[`UIM_EV_N-1:0] = im;
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  endfunction

  wire rd_go;
  wire wr_done;
  wire [`UIM_EV_N-1:0] ev;
  assign rd_go = bus_go & ~hwrite;
  assign wr_done = wr_pend_r;
  assign ev[`UIM_EV_RISE] = |(raw_s2_r & ~raw_d_r & mask_r);
  assign ev[`UIM_EV_WRITE] = wr_done & (wr_addr_r == `UIM_OFS_MASK);

  // ****************************************
  // Registers
  // ****************************************
  always @(posedge clock) begin
    if (!reset_n) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= {`UIM_ADDR_W{1'b0}};
      mask_r <= `UIM_MASK_RST;
      istat_r <= `UIM_EV_RST;
      imask_r <= `UIM_EV_RST;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      irq <= 1'b0;
    end else begin
      wr_pend_r <= bus_go & hwrite;
      if (bus_go) begin
        wr_addr_r <= a_ofs;
      end
      if (wr_done && wr_addr_r == `UIM_OFS_MASK) begin
        // Reserved bits are dropped on write
        mask_r <= hwdata[`UIM_FIELD_MSB:`UIM_FIELD_LSB];
      end
      if (wr_done && wr_addr_r == `UIM_OFS_IMASK) begin
        imask_r <= hwdata[`UIM_EV_N-1:0];
      end
      // Read clears, but a new event in the same cycle survives
      if (rd_go && a_ofs == `UIM_OFS_ISTAT) begin
        istat_r <= ev;
      end else begin
        istat_r <= istat_r | ev;
      end
      hrdata <= rd_go ? rd_mux(a_ofs, mask_r, istat_r, imask_r) : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      irq <= |(istat_r & imask_r);
    end
  end

  // ****************************************
  // Masked source outputs
  // ****************************************
  uim_gate u_gate (
    .clock(clock),
    .reset_n(reset_n),
    .raw_in(raw_s2_r),
    .enable(mask_r),
    .gated_r(masked_irq)
  );
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the UART interrupt mask gate
`timescale 1ns/1ps
module tb_top;
  logic clock = 0, reset_n = 0, hsel = 0, hwrite = 0, ack = 1, rp = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, s = 32'hb490, m, q[$];
  logic [6:0] raw_irq = 0, masked_irq, pend;
  logic hreadyout, hresp, irq;
  wire hready = hreadyout;
  int mismatches = 0, samples_checked = 0, cyc = 0;
  uim_top dut (
    .clock(clock),
    .reset_n(reset_n),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .raw_irq(raw_irq),
    .masked_irq(masked_irq),
    .irq(irq)
  );
  uim_ic_model ic (.clock(clock), .ack(ack), .masked_irq(masked_irq), .pend(pend));
  initial forever #4 clock = ~clock;
  task automatic test_done;
    if (mismatches == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] v);
    samples_checked++;
    if (e !== v) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", n, e, v);
    end
  endtask
  function automatic logic [31:0] xs(logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  // A read carries its expected word in d
  task automatic xfer(logic w, logic [11:0] a, logic [31:0] d);
    if (!w)
      q.push_back(d);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    do @(posedge clock); while (hready !== 1'b1);
    hsel <= 0;
    htrans <= 0;
    hwdata <= d;
    rp <= !w;
    do @(posedge clock); while (hready !== 1'b1);
    rp <= 0;
    @(posedge clock);
  endtask
  always @(posedge clock) begin
    if (rp)
      chk("hrdata", q.pop_front(), hrdata);
    if (++cyc > 5000) begin
      mismatches++;
      test_done();
    end
  end
  initial begin
    repeat (16) @(posedge clock);
    reset_n <= 1;
    ack <= 0;
    @(posedge clock);
    xfer(0, 12'h038, 0);
    for (int k = 0; k < 2; k++) begin
      xfer(1, 12'h044, 2 - 2 * k);
      xfer(1, 12'h038, 32'h7f0 * (1 - k));
      repeat (2) @(posedge clock);
      chk("irq", 1 - k, irq);
      xfer(0, 12'h040, 2);
      repeat (2) @(posedge clock);
      chk("irq", 0, irq);
    end
    for (int i = 0; i < 27; i++) begin
      s = xs(s);
      m = i < 7 ? 32'h10 << i : s;
      raw_irq <= s[18:12];
      xfer(1, 12'h038, m & 32'h7f0);
      xfer(0, 12'h038, m & 32'h7f0);
      ack <= 1;
      @(posedge clock);
      ack <= 0;
      repeat (4) @(posedge clock);
      chk("pend", s[18:12] & m[10:4], pend);
    end
    // Mid-run reset, then a rising enabled source must reach irq
    raw_irq <= 7'h00;
    repeat (4) @(posedge clock);
    reset_n <= 0;
    repeat (3) @(posedge clock);
    reset_n <= 1;
    @(posedge clock);
    xfer(0, 12'h038, 0);
    xfer(1, 12'h044, 1);
    xfer(1, 12'h038, 32'h7f0);
    chk("irq", 0, irq);
    raw_irq <= 7'h04;
    repeat (6) @(posedge clock);
    chk("irq", 1, irq);
    xfer(0, 12'h040, 3);
    repeat (2) @(posedge clock);
    chk("irq", 0, irq);
    xfer(0, 12'h100, 0);
    test_done();
  end
endmodule

// *** tb/uim_ic_model.sv ***
// Interrupt controller stand-in that latches masked requests
`timescale 1ns/1ps
module uim_ic_model (
  input logic clock,
  input logic ack,
  input logic [6:0] masked_irq,
  output logic [6:0] pend
);
  // Sticky, so a one-cycle leak of a blocked source is kept
  always @(posedge clock) begin
    pend <= ack ? masked_irq : pend | masked_irq;
  end
endmodule

// *** tb/uim_top_asserts.sv ***
// Port assertions for the UART interrupt mask gate
`timescale 1ns/1ps
module uim_chk (
  input logic clock,
  input logic reset_n,
  input logic hsel,
  input logic hready,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [31:0] hwdata,
  input logic [31:0] hrdata,
  input logic hreadyout,
  input logic hresp,
  input logic [6:0] raw_irq,
  input logic [6:0] masked_irq
);
  logic [6:0] m;
  logic w;
  wire hit = hsel && htrans[1] && hready && haddr[11:0] == 12'h038;
  wire rd = hit && !hwrite;
  // Mirror loads at the end of the write data phase
  always @(posedge clock) begin
    w <= reset_n && hit && hwrite;
    m <= !reset_n ? 7'h00 : w ? hwdata[10:4] : m;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  chk_mask_read: assert property (rd |=> hrdata[10:4] == $past(m))
    else $error("mask read");
  chk_gate_pass: assert property (masked_irq == ($past(raw_irq, 3) & $past(m)))
    else $error("gate pass");
  chk_gate_block: assert property ((masked_irq & ~$past(m)) == 7'h00)
    else $error("gate block");
  chk_tx_bit: assert property (rd |=> hrdata[5] == $past(m[1]))
    else $error("tx bit");
  chk_rx_bit: assert property (rd |=> hrdata[4] == $past(m[0]))
    else $error("rx bit");
  chk_rsvd_zero: assert property (rd |=> {hrdata[31:11], hrdata[3:0]} == 25'h0)
    else $error("reserved");
  chk_err_bits: assert property (rd |=> hrdata[10:6] == $past(m[6:2]))
    else $error("error bits");
  // Zero-wait slave: never stalls and never errors
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  chk_ready_high: assert property (hreadyout == 1'b1)
    else $error("ready low");
endmodule
bind uim_top uim_chk chk_i (
  .clock(clock),
  .reset_n(reset_n),
  .hsel(hsel),
  .hready(hready),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hwdata(hwdata),
  .hrdata(hrdata),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .raw_irq(raw_irq),
  .masked_irq(masked_irq)
);
